// ==== src/pbm_pkg.sv ====
// Shared constants and types for the push-button message control block.
package pbm_pkg;

	// Clock rate of the internal oscillator clock in hertz.
	localparam int unsigned CLK_HZ = 100_000_000;

	// Debounce interval in microseconds and its cycle count.
	localparam int unsigned DEBOUNCE_INTERVAL_US = 20_000;
	localparam int unsigned DEBOUNCE_INTERVAL_CYC = DEBOUNCE_INTERVAL_US * (CLK_HZ / 1_000_000);

	// Hold time that turns an erase press into a global erase, in milliseconds.
	localparam int unsigned GLOBAL_ERASE_MS = 3_000;
	localparam longint unsigned GLOBAL_ERASE_CYC = longint'(GLOBAL_ERASE_MS) * (CLK_HZ / 1_000);

	// Bit of the analog route configuration that enables pass-through.
	localparam int unsigned PASSTHROUGH_SEL_BIT = 6;

	// Width of the analog route configuration word.
	localparam int unsigned ROUTE_CFG_W = 12;

	// Width of the message pointer.
	localparam int unsigned MSG_PTR_W = 8;

	// Number of debounced buttons and their indices.
	localparam int unsigned NUM_BTN = 5;
	localparam int unsigned BTN_PASS = 0;
	localparam int unsigned BTN_PLAY = 1;
	localparam int unsigned BTN_ERASE = 2;
	localparam int unsigned BTN_SKIP = 3;
	localparam int unsigned BTN_CAPT = 4;

	// Operation states of the controller.
	typedef enum logic [2:0]
	{
		PBM_IDLE  = 3'b000,
		PBM_REC   = 3'b001,
		PBM_PLAY  = 3'b010,
		PBM_LOOP  = 3'b011,
		PBM_ERASE = 3'b100,
		PBM_GERA  = 3'b101,
		PBM_FWD   = 3'b110
	} pbm_state_t;

endpackage

// ==== src/pbm_debounce.sv ====
// Synchroniser and debouncer for one active-low button.
`timescale 1ns/10ps
`default_nettype none

module pbm_debounce
#(
	parameter int unsigned CYCLES     = 1000,
	parameter bit          RISE_DEBOUNCE = 1'b1
)
(
	input  wire logic i_clock,
	input  wire logic i_rst_n,
	input  wire logic i_button_n,
	output logic      o_level_n
);

	localparam int unsigned CW = $clog2(CYCLES + 1);

	// Two-stage synchroniser; the first stage feeds only the second.
	logic          sync1_q;
	logic          sync2_q;
	// Debounce counter and stable output level.
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          level_q;
	logic          level_d;

	// Next-value logic: a change must persist for CYCLES clocks to be accepted.
	always_comb
	begin
		cnt_d   = '0;
		level_d = level_q;
		if (sync2_q != level_q)
		begin
			// A release skips the delay when rise debounce is off, so capture ends at once.
			if (sync2_q && !RISE_DEBOUNCE)
			begin
				level_d = 1'b1;
			end
			else if (cnt_q == CW'(CYCLES - 1))
			begin
				level_d = sync2_q;
			end
			else
			begin
				cnt_d = cnt_q + CW'(1);
			end
		end
	end

	// Registers; idle buttons read high, as the weak pull-up would give.
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
			cnt_q   <= '0;
			level_q <= 1'b1;
		end
		else
		begin
			sync1_q <= i_button_n;
			sync2_q <= sync1_q;
			cnt_q   <= cnt_d;
			level_q <= level_d;
		end
	end

	assign o_level_n = level_q;

endmodule

`default_nettype wire

// ==== src/pbm_control.sv ====
// Push-button message controller: buttons to record, play, erase and skip operations.
`timescale 1ns/10ps
`default_nettype none

module pbm_control
#(
	parameter int unsigned     DEBOUNCE_CYC     = pbm_pkg::DEBOUNCE_INTERVAL_CYC,
	parameter longint unsigned GLOBAL_ERASE_CYC = pbm_pkg::GLOBAL_ERASE_CYC,
	parameter int unsigned     PTR_W            = pbm_pkg::MSG_PTR_W
)
(
	input  wire logic                              i_clock,
	input  wire logic                              i_rst_n,
	input  wire logic                              i_passthrough_button_n,
	input  wire logic                              i_play_button_n,
	input  wire logic                              i_erase_button_n,
	input  wire logic                              i_skip_next_button_n,
	input  wire logic                              i_capture_button_n,
	input  wire logic                              i_serial_mode,
	input  wire logic [pbm_pkg::ROUTE_CFG_W-1:0]   i_analog_route_config,
	input  wire logic                              i_serial_cmd_done,
	input  wire logic                              i_serial_int_clear,
	input  wire logic                              i_msg_end,
	input  wire logic [PTR_W-1:0]                  i_msg_count,
	input  wire logic                              i_op_done,
	output logic                                   o_passthrough_en,
	output logic                                   o_record_active,
	output logic                                   o_play_active,
	output logic                                   o_erase_start,
	output logic                                   o_global_erase_start,
	output logic [PTR_W-1:0]                       o_msg_ptr,
	output logic                                   o_ready_int_o,
	output logic                                   o_ready_int_oe
);

	localparam int unsigned GW = $clog2(GLOBAL_ERASE_CYC + 1);

	// Raw and debounced button levels, active low.
	logic [pbm_pkg::NUM_BTN-1:0] raw_n;
	logic [pbm_pkg::NUM_BTN-1:0] deb_n;
	// Previous debounced levels for edge detection.
	logic [pbm_pkg::NUM_BTN-1:0] prev_q;
	// Press and release events.
	logic [pbm_pkg::NUM_BTN-1:0] press;
	logic [pbm_pkg::NUM_BTN-1:0] release_e;

	// Controller state and outputs held in flip-flops.
	pbm_pkg::pbm_state_t state_q;
	pbm_pkg::pbm_state_t state_d;
	logic [PTR_W-1:0]    ptr_q;
	logic [PTR_W-1:0]    ptr_d;
	logic [GW-1:0]       hold_q;
	logic [GW-1:0]       hold_d;
	logic                loop_q;
	logic                loop_d;
	logic                erase_go_q;
	logic                erase_go_d;
	logic                gerase_go_q;
	logic                gerase_go_d;
	logic                pass_q;
	logic                pass_d;
	logic                int_q;
	logic                int_d;

	assign raw_n[pbm_pkg::BTN_PASS]  = i_passthrough_button_n;
	assign raw_n[pbm_pkg::BTN_PLAY]  = i_play_button_n;
	assign raw_n[pbm_pkg::BTN_ERASE] = i_erase_button_n;
	assign raw_n[pbm_pkg::BTN_SKIP]  = i_skip_next_button_n;
	assign raw_n[pbm_pkg::BTN_CAPT]  = i_capture_button_n;

	// One debouncer per button; only the capture button skips the release delay.
	genvar g;
	generate
		for (g = 0; g < pbm_pkg::NUM_BTN; g++)
		begin : g_btn
			pbm_debounce
			#(
				.CYCLES        (DEBOUNCE_CYC),
				.RISE_DEBOUNCE (g != pbm_pkg::BTN_CAPT)
			)
			u_deb
			(
				.i_clock    (i_clock),
				.i_rst_n    (i_rst_n),
				.i_button_n (raw_n[g]),
				.o_level_n  (deb_n[g])
			);
		end
	endgenerate

	// Edges of the debounced levels.
	assign press     = prev_q & ~deb_n;
	assign release_e = ~prev_q & deb_n;

	// The pointer is on the first or last stored message.
	logic at_end_msg;
	assign at_end_msg = (ptr_q == '0) || (ptr_q == i_msg_count - PTR_W'(1));

	// Operation sequencer: computes next state, pointer and one-shot starts.
	always_comb
	begin
		state_d     = state_q;
		ptr_d       = ptr_q;
		hold_d      = hold_q;
		loop_d      = loop_q;
		erase_go_d  = 1'b0;
		gerase_go_d = 1'b0;
		case (state_q)
			pbm_pkg::PBM_IDLE:
			begin
				// Buttons start operations only in standalone mode.
				if (i_serial_mode)
				begin
					state_d = pbm_pkg::PBM_IDLE;
				end
				else if (press[pbm_pkg::BTN_CAPT])
				begin
					state_d = pbm_pkg::PBM_REC;
				end
				else if (press[pbm_pkg::BTN_PLAY])
				begin
					state_d = pbm_pkg::PBM_PLAY;
					loop_d  = 1'b0;
					hold_d  = '0;
				end
				else if (press[pbm_pkg::BTN_ERASE] && at_end_msg)
				begin
					state_d = pbm_pkg::PBM_ERASE;
					hold_d  = '0;
				end
				else if (press[pbm_pkg::BTN_SKIP])
				begin
					state_d = pbm_pkg::PBM_FWD;
					ptr_d   = (ptr_q + PTR_W'(1) >= i_msg_count) ? '0 : ptr_q + PTR_W'(1);
				end
			end
			pbm_pkg::PBM_REC:
			begin
				// Release has no debounce delay, so recording stops at once.
				if (deb_n[pbm_pkg::BTN_CAPT])
				begin
					state_d = pbm_pkg::PBM_IDLE;
				end
			end
			pbm_pkg::PBM_PLAY, pbm_pkg::PBM_LOOP:
			begin
				// A press held one debounce interval beyond playback start means loop mode.
				if (!deb_n[pbm_pkg::BTN_PLAY] && hold_q < GW'(DEBOUNCE_CYC))
				begin
					hold_d = hold_q + GW'(1);
				end
				if (!deb_n[pbm_pkg::BTN_PLAY] && hold_q == GW'(DEBOUNCE_CYC - 1))
				begin
					loop_d  = 1'b1;
					state_d = pbm_pkg::PBM_LOOP;
				end
				if (state_q == pbm_pkg::PBM_LOOP && release_e[pbm_pkg::BTN_PLAY])
				begin
					loop_d = 1'b0;
				end
				if (press[pbm_pkg::BTN_PLAY])
				begin
					state_d = pbm_pkg::PBM_IDLE;
				end
				else if (press[pbm_pkg::BTN_SKIP])
				begin
					// Step without stopping: play stays active across the pointer move.
					ptr_d   = (ptr_q + PTR_W'(1) >= i_msg_count) ? '0 : ptr_q + PTR_W'(1);
					hold_d  = GW'(DEBOUNCE_CYC);
					state_d = pbm_pkg::PBM_PLAY;
				end
				else if (i_msg_end)
				begin
					if (loop_d)
					begin
						ptr_d = (ptr_q + PTR_W'(1) >= i_msg_count) ? '0 : ptr_q + PTR_W'(1);
					end
					else
					begin
						state_d = pbm_pkg::PBM_IDLE;
					end
				end
			end
			pbm_pkg::PBM_ERASE:
			begin
				// A short pulse erases one message; a long hold escalates.
				if (deb_n[pbm_pkg::BTN_ERASE])
				begin
					erase_go_d = 1'b1;
					state_d    = pbm_pkg::PBM_FWD;
				end
				else if (hold_q == GW'(GLOBAL_ERASE_CYC))
				begin
					gerase_go_d = 1'b1;
					ptr_d       = '0;
					state_d     = pbm_pkg::PBM_FWD;
				end
				else
				begin
					hold_d = hold_q + GW'(1);
				end
			end
			pbm_pkg::PBM_FWD:
			begin
				// Busy until the store reports the step or erase finished.
				if (i_op_done)
				begin
					state_d = pbm_pkg::PBM_IDLE;
				end
			end
			default:
			begin
				state_d = pbm_pkg::PBM_IDLE;
			end
		endcase
	end

	// Pass-through select and serial completion interrupt.
	always_comb
	begin
		pass_d = i_serial_mode ? i_analog_route_config[pbm_pkg::PASSTHROUGH_SEL_BIT]
		                       : ~deb_n[pbm_pkg::BTN_PASS];
		int_d = int_q;
		if (i_serial_int_clear)
		begin
			int_d = 1'b0;
		end
		// Completion wins over a clear in the same cycle so no event is lost.
		if (i_serial_cmd_done)
		begin
			int_d = 1'b1;
		end
	end

	// State registers.
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_q     <= pbm_pkg::PBM_IDLE;
			ptr_q       <= '0;
			hold_q      <= '0;
			loop_q      <= 1'b0;
			erase_go_q  <= 1'b0;
			gerase_go_q <= 1'b0;
			pass_q      <= 1'b0;
			int_q       <= 1'b0;
			prev_q      <= '1;
		end
		else
		begin
			state_q     <= state_d;
			ptr_q       <= ptr_d;
			hold_q      <= hold_d;
			loop_q      <= loop_d;
			erase_go_q  <= erase_go_d;
			gerase_go_q <= gerase_go_d;
			pass_q      <= pass_d;
			int_q       <= int_d;
			prev_q      <= deb_n;
		end
	end

	// Outputs come from registers; record and play are decoded from state_q.
	assign o_passthrough_en     = pass_q;
	assign o_record_active      = (state_q == pbm_pkg::PBM_REC);
	assign o_play_active        = (state_q == pbm_pkg::PBM_PLAY) || (state_q == pbm_pkg::PBM_LOOP);
	assign o_erase_start        = erase_go_q;
	assign o_global_erase_start = gerase_go_q;
	assign o_msg_ptr            = ptr_q;

	// Open drain: only ever pulls low; busy in standalone, interrupt in serial.
	assign o_ready_int_o  = 1'b0;
	assign o_ready_int_oe = i_serial_mode ? int_q : (state_q != pbm_pkg::PBM_IDLE);

endmodule

`default_nettype wire

// ==== testbench/pbm_control_asserts.sv ====
// Port-level checker for the push-button message controller.
`timescale 1ns/10ps
`default_nettype none
module pbm_control_asserts
#(
	parameter int unsigned PTR_W = 8
)
(
	input wire logic	i_clock,
	input wire logic	i_rst_n,
	input wire logic	i_passthrough_button_n,
	input wire logic	i_play_button_n,
	input wire logic	i_erase_button_n,
	input wire logic	i_skip_next_button_n,
	input wire logic	i_capture_button_n,
	input wire logic	i_serial_mode,
	input wire logic [pbm_pkg::ROUTE_CFG_W-1:0]	i_analog_route_config,
	input wire logic	i_serial_cmd_done,
	input wire logic	i_serial_int_clear,
	input wire logic	i_msg_end,
	input wire logic [PTR_W-1:0]	i_msg_count,
	input wire logic	i_op_done,
	input wire logic	o_passthrough_en,
	input wire logic	o_record_active,
	input wire logic	o_play_active,
	input wire logic	o_erase_start,
	input wire logic	o_global_erase_start,
	input wire logic [PTR_W-1:0]	o_msg_ptr,
	input wire logic	o_ready_int_o,
	input wire logic	o_ready_int_oe
);
	// One clock domain, so clocking and reset are given once.
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);

	a_route_bit_follow: assert property ($past(i_rst_n) && i_serial_mode && $past(i_serial_mode)
		|-> o_passthrough_en == $past(i_analog_route_config[pbm_pkg::PASSTHROUGH_SEL_BIT]))
		else $error("pass-through does not follow the route bit");
	a_pass_held_on: assert property ((!i_serial_mode && !i_passthrough_button_n) [*8]
		|-> o_passthrough_en) else $error("held pass-through button not honoured");
	a_pass_free_off: assert property ((!i_serial_mode && i_passthrough_button_n) [*8]
		|-> !o_passthrough_en) else $error("pass-through on with button released");
	a_ready_busy_low: assert property (!i_serial_mode && $past(!i_serial_mode)
		&& (o_record_active || o_play_active) |-> o_ready_int_oe && !o_ready_int_o)
		else $error("ready pin not pulled low while busy");
	a_int_set_done: assert property ($past(i_rst_n) && i_serial_mode && $past(i_serial_mode)
		&& $past(i_serial_cmd_done) |-> o_ready_int_oe) else $error("interrupt not raised");
	a_int_clear_off: assert property ($past(i_rst_n) && i_serial_mode && $past(i_serial_mode)
		&& !$past(i_serial_cmd_done) && $past(i_serial_int_clear) |-> !o_ready_int_oe)
		else $error("interrupt not cleared");
	a_rec_release_stop: assert property (i_capture_button_n [*6] |-> !o_record_active)
		else $error("recording outlives capture release");
	a_rec_start_low: assert property ($rose(o_record_active) |-> !$past(i_capture_button_n, 4))
		else $error("recording began without capture press");
	a_erase_edge_ptr: assert property (o_erase_start
		|-> o_msg_ptr == '0 || o_msg_ptr == i_msg_count - 1'b1) else $error("erase away from ends");
	a_erase_one_pulse: assert property (o_erase_start |=> !o_erase_start && !o_global_erase_start)
		else $error("erase pulse too long");
	a_global_ptr_zero: assert property (o_global_erase_start |=> o_msg_ptr == '0)
		else $error("pointer not cleared by global erase");
	a_ptr_single_step: assert property ($changed(o_msg_ptr)
		|-> o_msg_ptr == PTR_W'($past(o_msg_ptr) + 1'b1) || o_msg_ptr == '0)
		else $error("pointer jumped");

	c_play: cover property ($rose(o_play_active));
	c_rec: cover property ($rose(o_record_active));
	c_erase: cover property (o_erase_start);
	c_global: cover property (o_global_erase_start);
endmodule

bind pbm_control pbm_control_asserts #(.PTR_W(PTR_W)) u_chk (.*);
`default_nettype wire

// ==== testbench/pbm_store_model.sv ====
// Message store model: ends playback and finishes erase or skip work.
`timescale 1ns/10ps
`default_nettype none
module pbm_store_model
#(
	parameter int unsigned PLAY_LEN = 40,
	parameter int unsigned OP_DLY   = 6,
	parameter int unsigned PTR_W    = 8
)
(
	input  wire logic	i_clock,
	input  wire logic	i_rst_n,
	input  wire logic	i_play_active,
	input  wire logic	i_erase_start,
	input  wire logic	i_global_erase_start,
	input  wire logic [PTR_W-1:0]	i_msg_ptr,
	output logic	o_msg_end,
	output logic	o_op_done
);
	logic [15:0]	play_q;	// Cycles into the current message.
	logic [7:0]	op_q;	// Work left on an erase or skip.
	logic [PTR_W-1:0]	ptr_q;	// Pointer seen last cycle.
	// A larger OP_DLY models a slow store; idle skips show as pointer moves.
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			play_q <= '0;
			op_q <= '0;
			ptr_q <= '0;
			o_msg_end <= 1'b0;
			o_op_done <= 1'b0;
		end
		else
		begin
			ptr_q <= i_msg_ptr;
			o_msg_end <= 1'b0;
			o_op_done <= 1'b0;
			if (!i_play_active)
				play_q <= '0;
			else if (play_q == 16'(PLAY_LEN - 1))
			begin
				play_q <= '0;
				o_msg_end <= 1'b1;	// Message ran out.
			end
			else
				play_q <= play_q + 1'b1;
			if (op_q != '0)
			begin
				op_q <= op_q - 1'b1;
				o_op_done <= (op_q == 8'h01);
			end
			else if (i_erase_start || i_global_erase_start || (ptr_q != i_msg_ptr && !i_play_active))
				op_q <= 8'(OP_DLY);
		end
	end
endmodule
`default_nettype wire

// ==== testbench/push_button_message_control_tb_top.sv ====
// Testbench for the push-button message controller with an event scoreboard.
`timescale 1ns/10ps
`default_nettype none
module push_button_message_control_tb_top;
	logic	i_clock = 1'b0, i_rst_n = 1'b0, i_serial_mode = 1'b0;
	logic [4:0]	btn_n = 5'h1f;
	logic	i_serial_cmd_done = 1'b0, i_serial_int_clear = 1'b0;
	logic [11:0]	i_analog_route_config = 12'h000;
	logic [7:0]	i_msg_count = 8'h04, o_msg_ptr, pt_q = 8'h00;
	logic	i_msg_end, i_op_done, o_passthrough_en, o_record_active, o_play_active;
	logic	o_erase_start, o_global_erase_start, o_ready_int_o, o_ready_int_oe;
	logic	pl_q = 1'b0, rc_q = 1'b0, ge_q = 1'b0;
	int	mismatches = 0, samples_checked = 0;
	logic [31:0]	seed = 32'hebcca607;
	logic [11:0]	exp_q[$];	// Expected events: kind, then pointer.

	always #5 i_clock = ~i_clock;

	pbm_control #(.DEBOUNCE_CYC(4), .GLOBAL_ERASE_CYC(50)) dut (
		.i_passthrough_button_n(btn_n[0]), .i_play_button_n(btn_n[1]),
		.i_erase_button_n(btn_n[2]), .i_skip_next_button_n(btn_n[3]),
		.i_capture_button_n(btn_n[4]), .*);
	pbm_store_model #(.PLAY_LEN(40), .OP_DLY(9)) u_store (.i_clock, .i_rst_n,
		.i_play_active(o_play_active), .i_erase_start(o_erase_start),
		.i_global_erase_start(o_global_erase_start), .i_msg_ptr(o_msg_ptr),
		.o_msg_end(i_msg_end), .o_op_done(i_op_done));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge i_clock);
	endtask
	// Holds one button low for n cycles, changing pins on the falling edge.
	task automatic press(input int b, input int n);
		@(negedge i_clock) btn_n[b] = 1'b0;
		idle(n);
		btn_n[b] = 1'b1;
	endtask
	task automatic note(input logic [3:0] k, input logic [7:0] p);
		exp_q.push_back({k, p});
	endtask
	task automatic test_done();
		check("pending", 12'(exp_q.size()), 12'h000);
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Pointer on play-end and global-erase events is blanked, the store may move it then.
	// Outputs are sampled at the falling edge, half a cycle after they have settled.
	always @(negedge i_clock)
	begin : mon
		logic [3:0]  k;
		logic [11:0] rdy;
		k   = 4'h0;
		rdy = 12'h000;
		if (o_record_active != rc_q)
			k = o_record_active ? 4'h1 : 4'h2;
		else if (o_play_active != pl_q)
			k = o_play_active ? 4'h3 : 4'h4;
		else if (o_erase_start)
			k = 4'h5;
		else if (o_global_erase_start)
			k = 4'h6;
		else if (o_msg_ptr != pt_q && !ge_q)
			k = 4'h7;
		if (k != 4'h0)
		begin
			if (exp_q.size() == 0)
				check("unexpected", {k, o_msg_ptr}, 12'h000);
			else
				check("event", {k, (k == 4'h4 || k == 4'h6) ? 8'h00 : o_msg_ptr}, exp_q.pop_front());
			// Ends return to idle and release the pin; every other event leaves it pulled low.
			if (!i_serial_mode)
			begin
				rdy = (k == 4'h2 || k == 4'h4) ? 12'h000 : 12'h002;
				check("ready", 12'({o_ready_int_oe, o_ready_int_o}), rdy);
			end
		end
		rc_q <= o_record_active;
		pl_q <= o_play_active;
		ge_q <= o_global_erase_start;
		pt_q <= o_msg_ptr;
	end

	initial
	begin
		idle(3);
		i_rst_n = 1'b1;
		idle(4);
		note(4'h3, 8'h00);
		note(4'h4, 8'h00);
		press(1, 5);
		idle(70);
		note(4'h3, 8'h00);
		note(4'h4, 8'h00);
		press(1, 5);
		idle(15);
		press(1, 5);
		idle(40);
		note(4'h3, 8'h00);
		note(4'h7, 8'h01);
		note(4'h4, 8'h00);
		press(1, 5);
		idle(8);
		press(3, 5);
		idle(60);
		press(2, 5);
		idle(30);
		note(4'h7, 8'h02);
		note(4'h7, 8'h03);
		for (int i = 0; i < 2; i++)
		begin
			press(3, 5);
			idle(25 + rnd() % 8);
		end
		note(4'h5, 8'h03);
		press(2, 5);
		idle(40);
		note(4'h6, 8'h00);
		press(2, 80);
		idle(40);
		note(4'h3, 8'h00);
		note(4'h7, 8'h01);
		note(4'h7, 8'h02);
		note(4'h4, 8'h00);
		press(1, 100);
		idle(80);
		note(4'h1, 8'h02);
		note(4'h2, 8'h02);
		press(4, 30);
		idle(20);
		press(4, 2);
		idle(20);
		// A shorter store makes the pointer wrap from the last message to the first.
		i_msg_count = 8'h03;
		note(4'h7, 8'h00);
		press(3, 5);
		idle(30);
		btn_n[0] = 1'b0;
		idle(10);
		check("pass", 12'(o_passthrough_en), 12'h001);
		btn_n[0] = 1'b1;
		idle(10);
		check("pass", 12'(o_passthrough_en), 12'h000);
		i_serial_mode = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			i_analog_route_config = 12'(rnd());
			i_analog_route_config[pbm_pkg::PASSTHROUGH_SEL_BIT] = i[0];
			idle(2);
			check("route", 12'(o_passthrough_en), 12'(i[0]));
		end
		press(1, 5);
		idle(20);
		for (int i = 0; i < 3; i++)
		begin
			i_serial_cmd_done = 1'b1;
			idle(1);
			i_serial_cmd_done = 1'b0;
			idle(1 + rnd() % 4);
			check("int", 12'(o_ready_int_oe), 12'h001);
			i_serial_int_clear = 1'b1;
			idle(1);
			i_serial_int_clear = 1'b0;
			idle(1);
			check("int", 12'(o_ready_int_oe), 12'h000);
		end
		// Completion and clear in one cycle: the completion must not be lost.
		i_serial_cmd_done = 1'b1;
		i_serial_int_clear = 1'b1;
		idle(1);
		i_serial_cmd_done = 1'b0;
		i_serial_int_clear = 1'b0;
		idle(1);
		check("int", 12'(o_ready_int_oe), 12'h001);
		i_serial_int_clear = 1'b1;
		idle(1);
		i_serial_int_clear = 1'b0;
		idle(1);
		check("int", 12'(o_ready_int_oe), 12'h000);
		i_serial_mode = 1'b0;
		idle(10);
		test_done();
	end

	// Cuts a hang short well beyond the expected run length.
	initial
	begin
		repeat (20000) @(posedge i_clock);
		mismatches++;
		test_done();
	end
endmodule
`default_nettype wire
